// ### logic/gfs_enc.sv
`default_nettype none
module gfs_enc
    import gfs_pkg::*;
#(
    parameter int MAX_BANDS = 12,
    parameter int MAX_TILES = 4,
    parameter int F_W       = $clog2(MAX_BANDS + 1)
) (
    input  wire logic                                sys_clk,
    input  wire logic                                rst_b,
    input  wire logic                                frame_start,
    input  wire logic                                independent_frame_marker,
    input  wire logic                                write_output_enable,
    input  wire logic [2:0]                          tile_count,
    input  wire logic [F_W-1:0]                      band_count,
    input  wire logic [MAX_BANDS-1:0][GV_W-1:0]      scale_factors,
    input  wire logic [MAX_TILES-1:0][1:0]           current_whiten_levels,
    input  wire logic [GAIN_W-1:0]                   gain_reflection,
    input  wire logic [GAIN_W-1:0]                   gain_shaping,
    input  wire logic                                history_save,
    input  wire logic                                history_restore,
    output gfs_pkg::gfs_tbl_e                        tbl_query,
    output logic signed [gfs_pkg::CTX_W-1:0]         ctx_t_query,
    output logic signed [gfs_pkg::CTX_W-1:0]         ctx_f_query,
    input  wire logic signed [gfs_pkg::OFF_W-1:0]    table_offset,
    output logic                                     core_valid,
    output gfs_pkg::gfs_cmd_s                        core_cmd,
    input  wire logic                                core_ready,
    output logic                                     busy,
    output logic                                     done,
    output logic                                     temporal_flat_flag,
    output logic                                     history_valid
);
    import gfs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ZERO, ST_START, ST_BAND, ST_BITS, ST_FINISH, ST_DRAIN
    } gfs_state_e;

    gfs_state_e               state_r;
    gfs_state_e               state_nxt;
    logic                     rst_meta_r;
    logic                     rst_sync_b;
    logic [F_W-1:0]           f_r;
    logic [BITS_W-1:0]        bits_r;
    logic [LEN_W-1:0]         cnt_r;
    logic                     plain_r;
    logic                     t_r;
    logic                     t_save_r;
    logic [MAX_BANDS-1:0][GV_W-1:0] prev_r;
    logic [MAX_BANDS-1:0][GV_W-1:0] prev_save_r;
    logic [MAX_TILES-1:0][1:0]      previous_whiten_levels;
    logic                     wr_en_r;
    logic                     done_r;
    logic                     flat_r;
    logic                     accept;
    logic                     all_scales_zero_flag;
    logic                     first_split;
    logic                     last_band;
    logic [F_W-1:0]           fm1;
    logic [F_W-1:0]           fm2;
    logic signed [RES_W-1:0]  va;
    logic signed [RES_W-1:0]  vb;
    logic signed [RES_W-1:0]  vc;
    logic signed [RES_W-1:0]  ve;
    logic signed [RES_W-1:0]  residual;
    logic [SYM_W-1:0]         res_sym;
    logic [BITS_W-1:0]        esc_bits;
    logic [LEN_W-1:0]         esc_len;
    logic [LEN_W+BITS_W-1:0]  tail;
    gfs_cmd_s                 cmd;

    gfs_cmd_if cmd_link ();

    // reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    function automatic logic signed [RES_W-1:0] sx(input logic [GV_W-1:0] v);
        return $signed({{(RES_W - GV_W){1'b0}}, v});
    endfunction

    function automatic logic signed [CTX_W-1:0] quant_ctx(input logic signed [RES_W-1:0] x);
        if (x > RES_W'(CTX_LIM)) begin
            return CTX_W'(CTX_LIM);
        end else if (x < RES_W'(-CTX_LIM)) begin
            return CTX_W'(-CTX_LIM);
        end
        return x[CTX_W-1:0];
    endfunction

    // whitening levels followed by the flat bit, left aligned
    function automatic logic [LEN_W+BITS_W-1:0] tail_code(
        input logic [MAX_TILES-1:0][1:0] cur,
        input logic [MAX_TILES-1:0][1:0] prv,
        input logic [2:0]                tc,
        input logic                      indep,
        input logic                      flat
    );
        logic [BITS_W-1:0] acc;
        logic [LEN_W-1:0]  n;
        logic              same;
        logic              diff;
        acc  = '0;
        n    = '0;
        same = !indep;
        diff = 1'b0;
        for (int k = 0; k < MAX_TILES; k++) begin
            if (k < int'(tc) && cur[k] != prv[k]) begin
                same = 1'b0;
            end
        end
        if (same) begin
            acc = {acc[BITS_W-2:0], 1'b1};
            n   = n + LEN_W'(1);
        end else begin
            if (!indep) begin
                acc = {acc[BITS_W-2:0], 1'b0};
                n   = n + LEN_W'(1);
            end
            for (int k = 0; k < MAX_TILES; k++) begin
                if (k > 0 && k < int'(tc) && cur[k] != cur[k-1]) begin
                    diff = 1'b1;
                end
            end
            for (int k = 0; k < MAX_TILES; k++) begin
                if (k == 0 || (k < int'(tc) && diff)) begin
                    if (k == 1) begin
                        acc = {acc[BITS_W-2:0], diff};
                        n   = n + LEN_W'(1);
                    end
                    if (cur[k] == 2'h1) begin
                        acc = {acc[BITS_W-2:0], 1'b0};
                        n   = n + LEN_W'(1);
                    end else begin
                        acc = {acc[BITS_W-3:0], 1'b1, cur[k] != 2'h0};
                        n   = n + LEN_W'(2);
                    end
                end else if (k == 1) begin
                    acc = {acc[BITS_W-2:0], 1'b0};
                    n   = n + LEN_W'(1);
                end
            end
        end
        acc = {acc[BITS_W-2:0], flat};
        n   = n + LEN_W'(1);
        return {n, acc << (LEN_W'(BITS_W) - n)};
    endfunction

    assign all_scales_zero_flag = (scale_factors == '0);
    assign fm1 = (f_r == '0) ? '0 : f_r - F_W'(1);
    assign fm2 = (f_r < F_W'(2)) ? '0 : f_r - F_W'(2);
    assign va  = sx(prev_r[f_r]);
    assign vc  = sx(prev_r[fm1]);
    assign vb  = sx(scale_factors[fm1]);
    assign ve  = sx(scale_factors[fm2]);
    // t clear means no usable history, so a dependent frame codes its scale factors as independent
    assign first_split = !t_r && f_r == '0;
    assign last_band   = (f_r + F_W'(1) >= band_count);
    assign tail = tail_code(current_whiten_levels, previous_whiten_levels, tile_count,
                            independent_frame_marker, flat_r);

    always_comb begin
        tbl_query   = GFS_T_SE00;
        ctx_t_query = '0;
        ctx_f_query = '0;
        residual    = '0;
        if (!t_r) begin
            if (f_r == F_W'(1)) begin
                tbl_query = GFS_T_SE01;
                residual  = sx(scale_factors[f_r]) - vb;
            end else if (f_r != '0) begin
                tbl_query   = GFS_T_SE02;
                ctx_f_query = quant_ctx(vb - ve);
                residual    = sx(scale_factors[f_r]) - vb;
            end
        end else if (f_r == '0) begin
            tbl_query = GFS_T_SE10;
            residual  = sx(scale_factors[f_r]) - va;
        end else begin
            tbl_query   = GFS_T_SE11;
            ctx_f_query = quant_ctx(va - vc);
            ctx_t_query = quant_ctx(vb - vc);
            residual    = sx(scale_factors[f_r]) - (va + vb - vc);
        end
    end

    gfs_resid u_resid (
        .residual (residual),
        .offset   (table_offset),
        .symbol   (res_sym),
        .esc_bits (esc_bits),
        .esc_len  (esc_len)
    );

    // one item per state step; the core sees it through the buffer
    always_comb begin
        cmd          = '0;
        cmd.write_en = wr_en_r;
        cmd.tbl      = tbl_query;
        cmd.ctx_t    = ctx_t_query;
        cmd.ctx_f    = ctx_f_query;
        unique case (state_r)
            ST_ZERO: begin
                cmd.kind  = GFS_K_PLAIN;
                cmd.value = SYM_W'(all_scales_zero_flag);
            end
            ST_START: begin
                cmd.kind = GFS_K_START;
            end
            ST_BAND: begin
                cmd.kind  = GFS_K_SYM;
                cmd.value = first_split ? SYM_W'(scale_factors[0] >> LSB_N) : res_sym;
            end
            ST_BITS: begin
                cmd.kind  = plain_r ? GFS_K_PLAIN : GFS_K_ARBIT;
                cmd.value = SYM_W'(bits_r[BITS_W-1]);
            end
            ST_FINISH: begin
                cmd.kind = GFS_K_FINISH;
            end
            default: begin
                cmd.kind = GFS_K_START;
            end
        endcase
    end

    assign cmd_link.valid = (state_r != ST_IDLE) && (state_r != ST_DRAIN);
    assign cmd_link.cmd   = cmd;
    assign accept         = cmd_link.valid && cmd_link.ready;

    // two entries let the core stall for a cycle without a word being lost
    gfs_buf #(
        .WIDTH ($bits(gfs_cmd_s)),
        .DEPTH (2)
    ) u_buf (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .in_port    (cmd_link),
        .out_valid  (core_valid),
        .out_data   (core_cmd),
        .out_ready  (core_ready)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (frame_start) begin
                    state_nxt = ST_ZERO;
                end
            end
            ST_ZERO: begin
                if (accept) begin
                    state_nxt = all_scales_zero_flag ? ST_BITS : ST_START;
                end
            end
            ST_START: begin
                if (accept) begin
                    state_nxt = ST_BAND;
                end
            end
            ST_BAND: begin
                if (accept) begin
                    if (first_split || esc_len != '0) begin
                        state_nxt = ST_BITS;
                    end else if (last_band) begin
                        state_nxt = ST_FINISH;
                    end
                end
            end
            ST_BITS: begin
                if (accept && cnt_r == LEN_W'(1)) begin
                    if (plain_r) begin
                        state_nxt = ST_DRAIN;
                    end else if (f_r >= band_count) begin
                        state_nxt = ST_FINISH;
                    end else begin
                        state_nxt = ST_BAND;
                    end
                end
            end
            ST_FINISH: begin
                if (accept) begin
                    state_nxt = ST_BITS;
                end
            end
            ST_DRAIN: begin
                if (!core_valid) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // band index and the raw bit shifter
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            f_r     <= '0;
            bits_r  <= '0;
            cnt_r   <= '0;
            plain_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            f_r <= '0;
        end else if (accept) begin
            unique case (state_r)
                ST_BAND: begin
                    f_r     <= f_r + F_W'(1);
                    plain_r <= 1'b0;
                    if (first_split) begin
                        bits_r <= {scale_factors[0][LSB_N-1:0], 15'h0};
                        cnt_r  <= LEN_W'(LSB_N);
                    end else begin
                        bits_r <= esc_bits;
                        cnt_r  <= esc_len;
                    end
                end
                ST_BITS: begin
                    bits_r <= {bits_r[BITS_W-2:0], 1'b0};
                    cnt_r  <= cnt_r - LEN_W'(1);
                end
                ST_ZERO, ST_FINISH: begin
                    bits_r  <= tail[BITS_W-1:0];
                    cnt_r   <= tail[LEN_W+BITS_W-1:BITS_W];
                    plain_r <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // history valid bit and previous vector, with the shadow copy
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            t_r         <= HIST_RESET;
            t_save_r    <= HIST_RESET;
            prev_r      <= '0;
            prev_save_r <= '0;
        end else if (state_r == ST_IDLE) begin
            if (frame_start && independent_frame_marker) begin
                t_r <= 1'b0;
            end else if (history_restore) begin
                t_r    <= t_save_r;
                prev_r <= prev_save_r;
            end
            if (history_save) begin
                t_save_r    <= t_r;
                prev_save_r <= prev_r;
            end
        end else if (accept && state_r == ST_ZERO && all_scales_zero_flag) begin
            t_r <= 1'b0;
        end else if (accept && state_r == ST_FINISH) begin
            t_r    <= 1'b1;
            prev_r <= scale_factors;
        end
    end

    // per-frame latches, whitening history and the done pulse
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            previous_whiten_levels <= '0;
            wr_en_r                <= 1'b0;
            flat_r                 <= 1'b0;
            done_r                 <= 1'b0;
        end else begin
            done_r <= (state_r == ST_DRAIN) && !core_valid;
            if (state_r == ST_IDLE && frame_start) begin
                wr_en_r <= write_output_enable;
                flat_r  <= (gain_reflection < FLAT_LIMIT_Q12) &&
                           (gain_shaping < FLAT_LIMIT_Q12);
            end
            if (accept && (state_r == ST_FINISH ||
                           (state_r == ST_ZERO && all_scales_zero_flag))) begin
                previous_whiten_levels <= current_whiten_levels;
            end
        end
    end

    assign busy               = (state_r != ST_IDLE);
    assign done               = done_r;
    assign temporal_flat_flag = flat_r;
    assign history_valid      = t_r;
endmodule // gfs_enc
`default_nettype wire

// ### logic/gfs_pkg.sv
`default_nettype none
package gfs_pkg;
    localparam int GV_W          = 7;   // scale factor width, values 0..91
    localparam int RES_W         = 10;  // signed residual width
    localparam int SYM_W         = 5;
    localparam int BITS_W        = 17;  // longest raw run: 4 + 6 + 7
    localparam int LEN_W         = 5;
    localparam int OFF_W         = 8;
    localparam int CTX_W         = 3;
    localparam int GAIN_W        = 16;  // unsigned Q4.12 gain
    localparam int DIRECT_LOW    = -12;
    localparam int DIRECT_HIGH   = 12;
    localparam int SYM_TOP       = 26;  // alphabet of 27, top escape symbol
    localparam int ESC_SHORT_LIM = 15;
    localparam int ESC_MID_LIM   = 63;
    localparam int ESC_SHORT_N   = 4;
    localparam int ESC_MID_N     = 6;
    localparam int ESC_LONG_N    = 7;
    localparam int LSB_N         = 2;
    localparam int CTX_LIM       = 3;
    // 1.15 in Q4.12 is 4710.4, so below 1.15 means code below 4711
    localparam logic [GAIN_W-1:0] FLAT_LIMIT_Q12 = 16'h1267;
    localparam logic HIST_RESET = 1'b0;

    typedef enum logic [2:0] {
        GFS_K_START, GFS_K_SYM, GFS_K_ARBIT, GFS_K_FINISH, GFS_K_PLAIN
    } gfs_kind_e;

    typedef enum logic [2:0] {
        GFS_T_SE00, GFS_T_SE01, GFS_T_SE02, GFS_T_SE10, GFS_T_SE11
    } gfs_tbl_e;

    typedef struct packed {
        gfs_kind_e               kind;
        logic [SYM_W-1:0]        value;
        gfs_tbl_e                tbl;
        logic signed [CTX_W-1:0] ctx_t;
        logic signed [CTX_W-1:0] ctx_f;
        logic                    write_en;
    } gfs_cmd_s;
endpackage
`default_nettype wire

// ### logic/gfs_cmd_if.sv
`default_nettype none
interface gfs_cmd_if;
    import gfs_pkg::*;
    logic     valid;
    logic     ready;
    gfs_cmd_s cmd;
    modport src (output valid, output cmd, input ready);
    modport snk (input valid, input cmd, output ready);
endinterface
`default_nettype wire

// ### logic/gfs_resid.sv
`default_nettype none
module gfs_resid
    import gfs_pkg::*;
(
    input  wire logic signed [RES_W-1:0] residual,
    input  wire logic signed [OFF_W-1:0] offset,
    output logic [SYM_W-1:0]             symbol,
    output logic [BITS_W-1:0]            esc_bits,
    output logic [LEN_W-1:0]             esc_len
);
    logic signed [RES_W-1:0] x;
    logic        [RES_W-1:0] extra;

    always_comb begin
        x        = residual + RES_W'(offset);
        extra    = '0;
        esc_bits = '0;
        esc_len  = '0;
        if (x >= RES_W'(DIRECT_LOW) && x <= RES_W'(DIRECT_HIGH)) begin
            symbol = SYM_W'(x - RES_W'(DIRECT_LOW) + RES_W'(1));
        end else if (x < RES_W'(DIRECT_LOW)) begin
            symbol = '0;
            extra  = RES_W'(RES_W'(DIRECT_LOW - 1) - x);
        end else begin
            symbol = SYM_W'(SYM_TOP);
            extra  = RES_W'(x - RES_W'(DIRECT_HIGH + 1));
        end
        if (symbol == '0 || symbol == SYM_W'(SYM_TOP)) begin
            if (extra < RES_W'(ESC_SHORT_LIM)) begin
                esc_bits = {extra[ESC_SHORT_N-1:0], 13'h0};
                esc_len  = LEN_W'(ESC_SHORT_N);
            end else if (extra - RES_W'(ESC_SHORT_LIM) < RES_W'(ESC_MID_LIM)) begin
                esc_bits = {4'hf, 6'(extra - RES_W'(ESC_SHORT_LIM)), 7'h0};
                esc_len  = LEN_W'(ESC_SHORT_N + ESC_MID_N);
            end else begin
                esc_bits = {4'hf, 6'h3f,
                            7'(extra - RES_W'(ESC_SHORT_LIM + ESC_MID_LIM))};
                esc_len  = LEN_W'(ESC_SHORT_N + ESC_MID_N + ESC_LONG_N);
            end
        end
    end
endmodule // gfs_resid
`default_nettype wire

// ### logic/gfs_buf.sv
`default_nettype none
module gfs_buf
    import gfs_pkg::*;
#(
    parameter int WIDTH = $bits(gfs_cmd_s),
    parameter int DEPTH = 2
) (
    input  wire logic   sys_clk,
    input  wire logic   rst_sync_b,
    gfs_cmd_if.snk      in_port,
    output logic        out_valid,
    output logic [WIDTH-1:0] out_data,
    input  wire logic   out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_r;
    logic [PW-1:0]    rd_r;
    logic [CW-1:0]    cnt_r;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_port.ready = (cnt_r != CW'(DEPTH));
    assign out_valid     = (cnt_r != '0);
    assign out_data      = mem_r[rd_r];
    assign push          = in_port.valid && in_port.ready;
    assign pop           = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_r] <= WIDTH'(in_port.cmd);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wrap_inc(wr_r);
            end
            if (pop) begin
                rd_r <= wrap_inc(rd_r);
            end
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end
endmodule // gfs_buf
`default_nettype wire

// ### testbench/gfs_enc_properties.sv
`default_nettype none
module gfs_enc_props
    import gfs_pkg::*;
(
    input wire logic                       sys_clk,
    input wire logic                       rst_b,
    input wire logic                       frame_start,
    input wire logic                       independent_frame_marker,
    input wire logic                       write_output_enable,
    input wire logic [gfs_pkg::GAIN_W-1:0] gain_reflection,
    input wire logic [gfs_pkg::GAIN_W-1:0] gain_shaping,
    input wire logic                       core_ready,
    input wire logic                       core_valid,
    input wire gfs_pkg::gfs_cmd_s          core_cmd,
    input wire logic                       busy,
    input wire logic                       done,
    input wire logic                       temporal_flat_flag,
    input wire logic                       history_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire logic st = frame_start && !busy;
    AST_FLAT: assert property (st |=> temporal_flat_flag ==
        ($past(gain_reflection) < FLAT_LIMIT_Q12 && $past(gain_shaping) < FLAT_LIMIT_Q12))
        else $error("flat flag wrong");
    AST_BUSY: assert property (st |=> busy) else $error("busy not raised");
    AST_ZERO: assert property (st |-> ##[1:4] core_valid && core_cmd.kind == GFS_K_PLAIN)
        else $error("no leading bit");
    AST_DONE: assert property (done |-> !core_valid && !busy ##1 !done)
        else $error("done wrong");
    AST_HOLD: assert property (core_valid && !core_ready |=>
        core_valid && $stable(core_cmd)) else $error("item lost in stall");
    AST_ICLR: assert property (st && independent_frame_marker |=> !history_valid)
        else $error("history kept");
    AST_HSET: assert property (core_valid && core_ready && core_cmd.kind == GFS_K_FINISH
        |-> ##[0:2] history_valid) else $error("history not set");
    AST_WEN: assert property (busy && core_valid |->
        core_cmd.write_en == write_output_enable) else $error("write enable wrong");
    CVR_IND: cover property (st && independent_frame_marker);
    CVR_STALL: cover property (core_valid && !core_ready);
    CVR_COUNT: cover property (st && !write_output_enable);
endmodule // gfs_enc_props
bind gfs_enc gfs_enc_props u_gfs_enc_props (.*);
`default_nettype wire

// ### testbench/gfs_core_model.sv
`default_nettype none
module gfs_core_model
    import gfs_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        core_valid,
    input  wire gfs_pkg::gfs_cmd_s           core_cmd,
    output var logic                         core_ready = 1'h0,
    input  wire gfs_pkg::gfs_tbl_e           tbl_query,
    output logic signed [gfs_pkg::OFF_W-1:0] table_offset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] q[$];
    logic [1:0] n = 2'h0;
    // one table leans by one so the offset add is visible
    assign table_offset = (tbl_query == GFS_T_SE10) ? 8'sh01 : 8'sh00;
    // stall one cycle in three so the buffer must hold its words
    always @(posedge sys_clk) begin
        n <= (n == 2'h2) ? 2'h0 : n + 2'h1;
        core_ready <= (n != 2'h0);
        if (core_valid && core_ready) begin
            // table and contexts only matter for symbols, so others record zero there
            q.push_back({core_cmd.kind,
                (core_cmd.kind inside {GFS_K_START, GFS_K_FINISH}) ? 5'h00 : core_cmd.value,
                (core_cmd.kind == GFS_K_SYM) ?
                    {core_cmd.tbl, core_cmd.ctx_t, core_cmd.ctx_f} : 9'h000});
        end
    end
endmodule // gfs_core_model
`default_nettype wire

// ### testbench/tb_gfs_enc.sv
`default_nettype none
module tb_gfs_enc
    import gfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_b = 0, frame_start = 0, independent_frame_marker = 0;
    logic write_output_enable = 1, history_save = 0, history_restore = 0;
    logic core_ready, core_valid, busy, done, temporal_flat_flag, history_valid;
    logic [2:0] tile_count = 3'h1;
    logic [3:0] band_count = 4'h2;
    logic [11:0][6:0] scale_factors = '0;
    logic [3:0][1:0] current_whiten_levels = '0;
    logic [15:0] gain_reflection = '0, gain_shaping = '0;
    logic signed [7:0] table_offset;
    logic signed [2:0] ctx_t_query, ctx_f_query;
    gfs_tbl_e tbl_query;
    gfs_cmd_s core_cmd;
    logic [16:0] ex[$];
    int err_count = 0, check_count = 0, cyc = 0;
    gfs_enc u_gfs_enc (.*);
    gfs_core_model u_gfs_core_model (.*);
    always #20 sys_clk = ~sys_clk;
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input logic [16:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // c holds table and both contexts of a symbol, zero for every other item
    task automatic p(input logic [2:0] k, input logic [4:0] v, input logic [8:0] c = 9'h000);
        ex.push_back({k, v, c});
    endtask
    task automatic b(input logic [2:0] k, input logic [16:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) p(k, 5'(v[i]));
    endtask
    // band 0 of 40 split raw, band 1 residual -40 escapes to 15 then 12
    task automatic head();
        p(GFS_K_PLAIN, 0);
        p(GFS_K_START, 0);
        p(GFS_K_SYM, 5'h0a);
        b(GFS_K_ARBIT, 17'h0, 2);
        p(GFS_K_SYM, 5'h00, 9'h040);
        b(GFS_K_ARBIT, 17'hf, 4);
        b(GFS_K_ARBIT, 17'hc, 6);
        p(GFS_K_FINISH, 0);
    endtask
    task automatic run(input logic ind, wen, gh, input logic [6:0] g0, input logic hv);
        @(negedge sys_clk);
        independent_frame_marker = ind;
        write_output_enable = wen;
        scale_factors[0] = g0;
        gain_reflection = 16'h1266 + gh;
        gain_shaping = 16'h1266 + gh;
        frame_start = 1;
        @(negedge sys_clk);
        frame_start = 0;
        // a frame that never ends is caught by the cycle ceiling
        while (done !== 1'h1) @(negedge sys_clk);
        chk(8'(u_gfs_core_model.q.size()), 8'(ex.size()));
        foreach (ex[i]) chk(u_gfs_core_model.q[i], ex[i]);
        chk({7'h0, history_valid}, {7'h0, hv});
        u_gfs_core_model.q.delete();
        ex.delete();
        $display("frame test done");
    endtask
    task automatic pulse(input logic s);
        @(negedge sys_clk);
        history_save = s;
        history_restore = !s;
        @(negedge sys_clk);
        history_save = 0;
        history_restore = 0;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_b = 1;
        repeat (3) @(negedge sys_clk);
        head();
        b(GFS_K_PLAIN, 17'h9, 4);
        run(1, 1, 0, 7'h28, 1);
        pulse(1);
        b(GFS_K_PLAIN, 17'h6, 3);
        run(0, 0, 1, 7'h00, 0);
        pulse(0);
        chk({7'h0, history_valid}, 8'h01);
        b(GFS_K_PLAIN, 17'h0, 1);
        p(GFS_K_START, 0);
        p(GFS_K_SYM, 5'h0e, 9'h0c0);
        p(GFS_K_SYM, 5'h0d, 9'h105);
        p(GFS_K_FINISH, 0);
        b(GFS_K_PLAIN, 17'h2, 2);
        run(0, 1, 1, 7'h28, 1);
        b(GFS_K_PLAIN, 17'h7, 3);
        run(0, 1, 0, 7'h00, 0);
        head();
        b(GFS_K_PLAIN, 17'h3, 2);
        run(0, 1, 0, 7'h28, 1);
        // three tiles 1, 2, 1 and a top escape of 78 taking the long form
        tile_count = 3'h3;
        current_whiten_levels = 8'h19;
        scale_factors[1] = 7'h5b;
        p(GFS_K_PLAIN, 0);
        p(GFS_K_START, 0);
        p(GFS_K_SYM, 5'h00);
        b(GFS_K_ARBIT, 17'h0, 2);
        p(GFS_K_SYM, 5'h1a, 9'h040);
        b(GFS_K_ARBIT, 17'h1ff80, 17);
        p(GFS_K_FINISH, 0);
        b(GFS_K_PLAIN, 17'h1d, 6);
        run(1, 1, 0, 7'h00, 1);
        // dependent, levels changed to all 3: lead 0, code 11, diff 0
        current_whiten_levels = 8'h3f;
        scale_factors[1] = 7'h00;
        b(GFS_K_PLAIN, 17'h2d, 6);
        run(0, 1, 0, 7'h00, 0);
        conclude();
    end
endmodule // tb_gfs_enc
`default_nettype wire
